/* File: smf_framer.sv */
// Purpose: receive-side framer and checker for secure messaging data fields
// Assumes: header and data field arrive as one byte stream, in_last on final byte
// Notes: mac and cipher engines sit outside; only the mac engine is reached by feed, req and done
`timescale 1ns/1ps
module smf_framer (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_last,
  output logic in_ready,
  input wire logic cfg_conf,
  input wire logic [3:0] cfg_mac_len,
  input wire logic [7:0] cfg_data_len,
  output logic mac_feed_valid,
  output logic [7:0] mac_feed_byte,
  output logic mac_req,
  input wire logic mac_done,
  input wire logic [smf_pkg::MAC_FULL_BITS-1:0] mac_result,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic [7:0] pt_len,
  output logic tagged_mode,
  output logic wrapped,
  output logic enc_covered,
  output logic done,
  output logic mac_ok,
  output logic fmt_err
);
  typedef enum logic [9:0] {
    S_HDR = 10'h001, S_TAG = 10'h002, S_LEN = 10'h004, S_VAL = 10'h008,
    S_MTAG = 10'h010, S_MLEN = 10'h020, S_MAC = 10'h040, S_PDAT = 10'h080,
    S_CALC = 10'h100, S_SKIP = 10'h200
  } smf_state_type;
  // S_FIN folded as a done pulse; a command ends back in S_HDR via FIN below
  smf_state_type state_reg, state_next; // main sequencer
  logic fin_reg, fin_next; // closing cycle of a command
  logic cmp_reg, cmp_next; // comparing stored mac
  logic [7:0] cnt_reg, cnt_next; // byte counter
  logic [7:0] l1_reg, l1_next; // data object length
  logic [3:0] mlen_reg, mlen_next; // mac length in use
  logic [smf_pkg::MAC_FULL_BITS-1:0] res_reg, res_next; // mac result
  logic mis_reg, mis_next; // mac mismatch seen
  logic rdy_reg, rdy_next, fv_reg, fv_next, req_reg, req_next; // handshake flops
  logic [7:0] fb_reg, fb_next, ob_reg, ob_next, pl_reg, pl_next; // byte outputs
  logic ov_reg, ov_next, tg_reg, tg_next, wr_reg, wr_next, cv_reg, cv_next; // flags
  logic dn_reg, dn_next, ok_reg, ok_next, err_reg, err_next; // result flags
  logic fire; // byte taken this cycle
  logic bad; // format fault on this byte

  smf_mem_if #(.AW(smf_pkg::MAC_AW), .DW(smf_pkg::MAC_DW)) mif ();
  smf_mac_store #(.AW(smf_pkg::MAC_AW), .DW(smf_pkg::MAC_DW)) u_store (
    .mclk(mclk),
    .port(mif.mem)
  );

  // legal mac length check
  function automatic logic smf_len_ok(input logic [7:0] n);
    return (n >= smf_pkg::MAC_MIN) && (n <= smf_pkg::MAC_MAX);
  endfunction

  // byte i of the result, counted from the most significant end
  function automatic logic [7:0] smf_res_byte(input logic [63:0] r, input logic [2:0] i);
    logic [63:0] s;
    s = r << {i, 3'h0};
    return s[63:56];
  endfunction

  assign fire = in_valid & rdy_reg;

  // next-state and datapath decisions
  always_comb begin
    state_next = state_reg;
    fin_next = 1'b0;
    cmp_next = cmp_reg;
    cnt_next = cnt_reg;
    l1_next = l1_reg;
    mlen_next = mlen_reg;
    res_next = res_reg;
    mis_next = mis_reg;
    fv_next = 1'b0;
    fb_next = fb_reg;
    req_next = 1'b0;
    ov_next = 1'b0;
    ob_next = ob_reg;
    pl_next = pl_reg;
    tg_next = tg_reg;
    wr_next = wr_reg;
    cv_next = cv_reg;
    dn_next = 1'b0;
    ok_next = ok_reg;
    err_next = err_reg;
    bad = 1'b0;
    mif.we = 1'b0;
    mif.waddr = cnt_reg[2:0];
    mif.wdata = in_byte;
    fb_next = fire ? in_byte : fb_reg;
    if (fin_reg) begin
      // closing pulse with verdict
      dn_next = 1'b1;
      ok_next = !err_reg && !mis_reg;
    end else if (cmp_reg) begin
      // compare leftmost result bytes with stored mac
      if (mif.rdata != smf_res_byte(res_reg, cnt_reg[2:0])) begin
        mis_next = 1'b1;
      end
      if (cnt_reg == {4'h0, mlen_reg} - smf_pkg::CNT_ONE) begin
        cmp_next = 1'b0;
        fin_next = 1'b1;
        cnt_next = 8'h00;
      end else begin
        cnt_next = cnt_reg + smf_pkg::CNT_ONE;
      end
    end else begin
      unique case (state_reg)
        S_HDR: if (fire) begin
          fv_next = 1'b1;
          if (cnt_reg == 8'h00) begin
            err_next = 1'b0;
            mis_next = 1'b0;
            wr_next = 1'b0;
            cv_next = 1'b1;
            mlen_next = cfg_mac_len;
            if (in_byte[3:0] == smf_pkg::CLS_TAGGED) begin
              tg_next = 1'b1;
            end else if (in_byte[3:0] == smf_pkg::CLS_POSITIONAL) begin
              tg_next = 1'b0;
              bad = !smf_len_ok({4'h0, cfg_mac_len});
            end else begin
              tg_next = 1'b0; // level follows the last class nibble
              bad = 1'b1;
            end
          end
          if (cnt_reg == smf_pkg::HDR_LAST) begin
            cnt_next = 8'h00;
            state_next = tg_reg ? S_TAG : ((cfg_data_len != 8'h00) ? S_PDAT : S_MAC);
          end else begin
            cnt_next = cnt_reg + smf_pkg::CNT_ONE;
          end
          if (in_last) begin
            bad = 1'b1;
          end
        end
        S_TAG: if (fire) begin
          if (in_byte == smf_pkg::TAG_MAC) begin
            state_next = S_MLEN;
          end else begin
            // context-specific even tag only legal for a cryptogram
            if (!cfg_conf && in_byte >= smf_pkg::TAG_CTX_LO && in_byte <= smf_pkg::TAG_CTX_HI
                && !in_byte[0]) begin
              bad = 1'b1;
            end
            cv_next = cfg_conf ? in_byte[0] : 1'b1;
            wr_next = (in_byte == smf_pkg::TAG_WRAP);
            fv_next = cfg_conf ? in_byte[0] : 1'b1;
            state_next = S_LEN;
          end
          bad = bad | in_last;
        end
        S_LEN: if (fire) begin
          fv_next = cv_reg;
          bad = in_byte[7] | in_last; // long form lengths not handled
          l1_next = in_byte;
          cnt_next = 8'h00;
          state_next = (in_byte == 8'h00) ? S_MTAG : S_VAL;
        end
        S_VAL: if (fire) begin
          fv_next = cv_reg;
          ov_next = 1'b1;
          ob_next = in_byte;
          cnt_next = cnt_reg + smf_pkg::CNT_ONE;
          if (cnt_reg == l1_reg - smf_pkg::CNT_ONE) begin
            state_next = S_MTAG;
          end
          bad = in_last;
        end
        S_MTAG: if (fire) begin
          bad = (in_byte != smf_pkg::TAG_MAC) | in_last;
          state_next = S_MLEN;
        end
        S_MLEN: if (fire) begin
          bad = !smf_len_ok(in_byte) | in_last;
          mlen_next = in_byte[3:0];
          cnt_next = 8'h00;
          state_next = S_MAC;
        end
        S_MAC: if (fire) begin
          // mac bytes are stored, never fed to the engine
          mif.we = 1'b1;
          cnt_next = cnt_reg + smf_pkg::CNT_ONE;
          if (cnt_reg == {4'h0, mlen_reg} - smf_pkg::CNT_ONE) begin
            bad = !in_last;
            state_next = S_CALC;
            req_next = 1'b1;
          end else begin
            bad = in_last;
          end
        end
        S_PDAT: if (fire) begin
          fv_next = 1'b1;
          if (cfg_conf && cnt_reg == 8'h00) begin
            pl_next = in_byte;
          end else begin
            ov_next = 1'b1;
            ob_next = in_byte;
          end
          cnt_next = cnt_reg + smf_pkg::CNT_ONE;
          if (cnt_reg == cfg_data_len - smf_pkg::CNT_ONE) begin
            cnt_next = 8'h00;
            state_next = S_MAC;
          end
          bad = in_last;
        end
        S_CALC: if (mac_done) begin
          res_next = mac_result;
          cnt_next = 8'h00;
          cmp_next = 1'b1;
          state_next = S_HDR;
        end
        S_SKIP: if (fire && in_last) begin
          fin_next = 1'b1;
          state_next = S_HDR;
        end
        default: state_next = S_HDR;
      endcase
      if (bad) begin
        err_next = 1'b1;
        cnt_next = 8'h00;
        req_next = 1'b0;
        fin_next = in_last;
        state_next = in_last ? S_HDR : S_SKIP;
      end
    end
    mif.raddr = cnt_next[2:0];
    // no input taken while waiting, comparing or closing
    rdy_next = !(state_next == S_CALC || cmp_next || fin_next);
  end

  // state registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_HDR;
      fin_reg <= 1'b0;
      cmp_reg <= 1'b0;
      cnt_reg <= 8'h00;
      l1_reg <= 8'h00;
      mlen_reg <= 4'h0;
      res_reg <= '0;
      mis_reg <= 1'b0;
      rdy_reg <= 1'b0;
      fv_reg <= 1'b0;
      fb_reg <= 8'h00;
      req_reg <= 1'b0;
      ov_reg <= 1'b0;
      ob_reg <= 8'h00;
      pl_reg <= 8'h00;
      tg_reg <= 1'b0;
      wr_reg <= 1'b0;
      cv_reg <= 1'b0;
      dn_reg <= 1'b0;
      ok_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fin_reg <= fin_next;
      cmp_reg <= cmp_next;
      cnt_reg <= cnt_next;
      l1_reg <= l1_next;
      mlen_reg <= mlen_next;
      res_reg <= res_next;
      mis_reg <= mis_next;
      rdy_reg <= rdy_next;
      fv_reg <= fv_next;
      fb_reg <= fb_next;
      req_reg <= req_next;
      ov_reg <= ov_next;
      ob_reg <= ob_next;
      pl_reg <= pl_next;
      tg_reg <= tg_next;
      wr_reg <= wr_next;
      cv_reg <= cv_next;
      dn_reg <= dn_next;
      ok_reg <= ok_next;
      err_reg <= err_next;
    end
  end

  assign in_ready = rdy_reg;
  assign mac_feed_valid = fv_reg;
  assign mac_feed_byte = fb_reg;
  assign mac_req = req_reg;
  assign out_valid = ov_reg;
  assign out_byte = ob_reg;
  assign pt_len = pl_reg;
  assign tagged_mode = tg_reg;
  assign wrapped = wr_reg;
  assign enc_covered = cv_reg;
  assign done = dn_reg;
  assign mac_ok = ok_reg;
  assign fmt_err = err_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_class_tagged: assert property (state_reg == S_HDR && !cmp_reg && !fin_reg && fire && cnt_reg == 8'h00
    && in_byte[3:0] == smf_pkg::CLS_TAGGED |=> tagged_mode) else $error("tagged layout not chosen");
  a_class_pos: assert property (state_reg == S_HDR && !cmp_reg && !fin_reg && fire && cnt_reg == 8'h00
    && in_byte[3:0] == smf_pkg::CLS_POSITIONAL |=> !tagged_mode) else $error("positional layout not chosen");
  a_header_fed: assert property (state_reg == S_HDR && !cmp_reg && !fin_reg && fire
    |=> mac_feed_valid && mac_feed_byte == $past(in_byte)) else $error("header byte not fed to mac");
  a_ctx_even_err: assert property (state_reg == S_TAG && !cmp_reg && !fin_reg && fire && !cfg_conf
    && in_byte[7:6] == 2'h2 && !in_byte[0] && in_byte != smf_pkg::TAG_MAC |=> fmt_err) else $error("even ctx tag taken");
  a_wrap_flag: assert property (state_reg == S_TAG && !cmp_reg && !fin_reg && fire
    && in_byte == smf_pkg::TAG_WRAP |=> wrapped) else $error("wrapper tag not flagged");
  a_mac_len_ok: assert property (state_reg == S_MAC && !cmp_reg && !fin_reg
    |-> mlen_reg >= 4'h4 && mlen_reg <= 4'h8) else $error("mac length out of range");
  a_mac_not_fed: assert property (state_reg == S_MAC && !cmp_reg && !fin_reg && fire
    |=> !mac_feed_valid) else $error("mac byte fed to engine");
  a_pos_split: assert property (state_reg == S_PDAT && !cmp_reg && !fin_reg && fire && !in_last
    && cnt_reg == cfg_data_len - 8'h01 |=> state_reg == S_MAC) else $error("positional split wrong");
  a_cmp_bound: assert property (cmp_reg |-> cnt_reg < {4'h0, mlen_reg}) else $error("compare past mac length");
  a_enc_cover: assert property (state_reg == S_TAG && !cmp_reg && !fin_reg && fire && cfg_conf
    && in_byte != smf_pkg::TAG_MAC |=> enc_covered == $past(in_byte[0])) else $error("cover flag wrong");
  a_pt_len: assert property (state_reg == S_PDAT && !cmp_reg && !fin_reg && fire && cfg_conf
    && cnt_reg == 8'h00 |=> pt_len == $past(in_byte) && !out_valid) else $error("length byte misplaced");
  a_req_wait: assert property (mac_req |-> !in_ready && state_reg == S_CALC ##1 !mac_req && !in_ready)
    else $error("request not a pulse or input open");
  a_bad_class: assert property (state_reg == S_HDR && !cmp_reg && !fin_reg && fire && cnt_reg == 8'h00
    && in_byte[3:0] != smf_pkg::CLS_TAGGED && in_byte[3:0] != smf_pkg::CLS_POSITIONAL |=> fmt_err)
    else $error("bad class not flagged");
endmodule

/* File: smf_mac_engine_model.sv */
// Purpose: behavioural mac engine facing the framer
// Assumes: one clock, request pulse sampled between edges
// Notes: answers after a bench-chosen delay, result bus churns when idle
`timescale 1ns/1ps
module smf_mac_engine_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mac_req,
  input wire logic [7:0] dly,
  input wire logic [63:0] mac_val,
  output logic mac_done,
  output logic [63:0] mac_result
);
  initial begin
    mac_done = 1'b0;
    mac_result = 64'h0F1E2D3C4B5A6978;
  end
  // wait for a request, then answer with one done pulse dly+1 clock edges later
  always begin
    @(negedge mclk);
    if (mac_req === 1'b1 && sys_rst === 1'b0) begin
      repeat (dly) begin
        @(posedge mclk);
        #1 mac_result = ~mac_result;
      end
      @(posedge mclk);
      #1 mac_done = 1'b1;
      mac_result = mac_val;
      @(posedge mclk);
      #1 mac_done = 1'b0;
      mac_result = ~mac_val;
    end else begin
      // idle: result carries nothing, so it keeps changing
      @(posedge mclk);
      #1 mac_result = {mac_result[62:0], ~mac_result[63]};
    end
  end
endmodule

/* File: smf_mac_store.sv */
// Purpose: small store for received mac bytes
// Assumes: read data valid one cycle after the address
// Notes: contents are not reset, only read after being written
`timescale 1ns/1ps
module smf_mac_store #(
  parameter int AW = 3,
  parameter int DW = 8
) (
  input wire logic mclk,
  smf_mem_if.mem port
);
  logic [DW-1:0] mem_reg [0:(1<<AW)-1]; // byte array
  logic [DW-1:0] rd_reg; // read data register

  // write and registered read
  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem_reg[port.waddr] <= port.wdata;
    end
    rd_reg <= mem_reg[port.raddr];
  end

  assign port.rdata = rd_reg;
endmodule

/* File: smf_mem_if.sv */
// Purpose: carrier between framer control and its mac byte store
// Assumes: single clock, registered read
// Notes: ctl drives addresses and writes, mem returns data
`timescale 1ns/1ps
interface smf_mem_if #(parameter int AW = 3, parameter int DW = 8);
  logic we; // write strobe
  logic [AW-1:0] waddr; // write address
  logic [DW-1:0] wdata; // write data
  logic [AW-1:0] raddr; // read address
  logic [DW-1:0] rdata; // registered read data
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

/* File: smf_pkg.sv */
// Purpose: shared constants for the secure message field framer
// Assumes: byte-wide command stream, header first
// Notes: all codes are fixed by the message format
package smf_pkg;
  localparam logic [3:0] CLS_TAGGED = 4'hC; // class nibble, tagged layout
  localparam logic [3:0] CLS_POSITIONAL = 4'h4; // class nibble, positional layout
  localparam logic [7:0] TAG_MAC = 8'h8E; // mac object tag
  localparam logic [7:0] TAG_WRAP = 8'h81; // wrapper for non-tlv data
  localparam logic [7:0] TAG_CTX_LO = 8'h80; // context-specific range low
  localparam logic [7:0] TAG_CTX_HI = 8'hBF; // context-specific range high
  localparam logic [7:0] MAC_MIN = 8'h04; // shortest mac, bytes
  localparam logic [7:0] MAC_MAX = 8'h08; // longest mac, bytes
  localparam int MAC_FULL_BITS = 64; // full mac result width
  localparam logic [7:0] HDR_LAST = 8'h03; // index of last header byte
  localparam logic [7:0] CNT_ONE = 8'h01; // counter step
  localparam int MAC_AW = 3; // mac store address width
  localparam int MAC_DW = 8; // mac store data width
endpackage

/* File: tb.sv */
// Purpose: self-checking bench for the secure message field framer
// Assumes: mac engine model on the far side, bytes driven 1 ns after the edge
// Notes: expectations queued by the driver, popped by a negedge monitor
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb;
  logic mclk = 1'b0, sys_rst = 1'b1, in_valid = 1'b0, in_last = 1'b0, cfg_conf = 1'b0;
  logic [7:0] in_byte = 8'h00, cfg_data_len = 8'h00, eng_dly = 8'h00, pt_len, out_byte, mac_feed_byte;
  logic [3:0] cfg_mac_len = 4'h4;
  logic [63:0] mac_v = 64'h0, mac_result;
  logic in_ready, mac_feed_valid, mac_req, mac_done, out_valid, tagged_mode, wrapped, enc_covered, done, mac_ok, fmt_err;
  logic [7:0] exp_feed[$], exp_out[$], ef, eo;
  logic [12:0] exp_done[$], msk_done[$], ed, md;
  logic [31:0] seed = 32'h892d;
  int errors = 0, comparisons = 0, ndone = 0, ntest = 0, cycles = 0;
  bit strict = 1'b1;
  smf_framer u_smf_framer (.mclk(mclk), .sys_rst(sys_rst), .in_valid(in_valid), .in_byte(in_byte),
    .in_last(in_last), .in_ready(in_ready), .cfg_conf(cfg_conf), .cfg_mac_len(cfg_mac_len),
    .cfg_data_len(cfg_data_len), .mac_feed_valid(mac_feed_valid), .mac_feed_byte(mac_feed_byte),
    .mac_req(mac_req), .mac_done(mac_done), .mac_result(mac_result), .out_valid(out_valid),
    .out_byte(out_byte), .pt_len(pt_len), .tagged_mode(tagged_mode), .wrapped(wrapped),
    .enc_covered(enc_covered), .done(done), .mac_ok(mac_ok), .fmt_err(fmt_err));
  smf_mac_engine_model u_smf_mac_engine_model (.mclk(mclk), .sys_rst(sys_rst), .mac_req(mac_req),
    .dly(eng_dly), .mac_val(mac_v), .mac_done(mac_done), .mac_result(mac_result));
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // counts, verdict, end of run
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  // monitor: compare each done result, and feed and out bytes of error-free commands, with the oldest note
  always @(negedge mclk) begin
    if (mac_feed_valid === 1'b1 && strict) begin
      ef = exp_feed.size() ? exp_feed.pop_front() : 8'hxx;
      `CHK(mac_feed_byte, ef)
    end
    if (out_valid === 1'b1 && strict) begin
      eo = exp_out.size() ? exp_out.pop_front() : 8'hxx;
      `CHK(out_byte, eo)
    end
    if (done === 1'b1) begin
      ed = exp_done.size() ? exp_done.pop_front() : 'x;
      md = msk_done.size() ? msk_done.pop_front() : 13'h1FFF;
      `CHK({pt_len, tagged_mode, wrapped, enc_covered, mac_ok, fmt_err} & md, ed & md)
      ndone++;
    end
  end
  // build one command, note expectations, send it and wait for done
  task automatic do_cmd(input logic [7:0] cls, input bit pos, input bit conf, input logic [7:0] tag,
                        input int dlen, input logic [7:0] mtag, input int mlen, input bit good, input bit err);
    logic [7:0] cmd[$];
    logic [7:0] b;
    logic [7:0] ptl;
    int k, w, nd;
    bit tg;
    tg = (cls[3:0] == smf_pkg::CLS_TAGGED);
    mac_v = {rnd(), rnd()};
    eng_dly = 8'(rnd() % 8);
    strict = !err;
    cmd = {cls, 8'(rnd()), 8'(rnd()), 8'(rnd())};
    if (!err) exp_feed = {exp_feed, cmd};
    ptl = 8'h00;
    if (!tg) begin
      // positional: agreed lengths, plaintext length first when enciphered
      for (k = 0; k < dlen; k++) begin
        b = 8'(rnd());
        if (k == 0 && conf) ptl = b;
        cmd.push_back(b);
        if (!err) exp_feed.push_back(b);
        if (!err && !(k == 0 && conf)) exp_out.push_back(b);
      end
    end else begin
      // tagged: data object, then mac object
      cmd.push_back(tag);
      cmd.push_back(dlen[7:0]);
      if (!err && (!conf || tag[0])) exp_feed = {exp_feed, tag, dlen[7:0]};
      for (k = 0; k < dlen; k++) begin
        b = 8'(rnd());
        cmd.push_back(b);
        if (!err && (!conf || tag[0])) exp_feed.push_back(b);
        if (!err) exp_out.push_back(b);
      end
      cmd.push_back(mtag);
      cmd.push_back(mlen[7:0]);
    end
    // leftmost mac bytes, first one spoiled for a mismatch
    for (k = 0; k < mlen; k++) begin
      b = (k < 8) ? mac_v[63 - 8 * k -: 8] : 8'h55;
      if (!good && k == 0) b = ~b;
      cmd.push_back(b);
    end
    exp_done.push_back({ptl, tg, tag == smf_pkg::TAG_WRAP, tag[0], good && !err, err});
    msk_done.push_back({(pos && conf && !err) ? 8'hFF : 8'h00, 1'b1, tg && !err, tg && conf && !err, 2'b11});
    nd = ndone;
    @(posedge mclk);
    #1 cfg_conf = conf;
    cfg_mac_len = mlen[3:0];
    cfg_data_len = dlen[7:0];
    for (k = 0; k < cmd.size(); k++) begin
      in_valid = 1'b1;
      in_byte = cmd[k];
      in_last = (k == cmd.size() - 1);
      w = 0;
      do begin
        @(negedge mclk);
        w++;
      end while (in_ready !== 1'b1 && w < 100);
      // a byte never accepted counts as a fault
      if (in_ready !== 1'b1) errors++;
      @(posedge mclk);
      #1;
    end
    in_valid = 1'b0;
    in_last = 1'b0;
    w = 0;
    while (ndone == nd && w < 300) begin
      @(negedge mclk);
      w++;
    end
    // no done pulse within the limit counts as a fault
    if (ndone == nd) errors++;
    ntest++;
    $display("test %0d end", ntest);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
    do_cmd(8'h0C, 0, 0, 8'h81, 3, 8'h8E, 8, 1, 0);
    do_cmd(8'h8C, 0, 0, 8'h53, 2, 8'h8E, 4, 1, 0);
    do_cmd(8'h0C, 0, 0, 8'h83, 1, 8'h8E, 5, 0, 0);
    do_cmd(8'h0C, 0, 0, 8'h82, 2, 8'h8E, 8, 1, 1);
    do_cmd(8'h0C, 0, 0, 8'h81, 2, 8'h8F, 8, 1, 1);
    do_cmd(8'h0C, 0, 0, 8'h81, 2, 8'h8E, 3, 1, 1);
    do_cmd(8'h0C, 0, 0, 8'h81, 2, 8'h8E, 9, 1, 1);
    do_cmd(8'h00, 0, 0, 8'h81, 2, 8'h8E, 8, 1, 1);
    do_cmd(8'h0C, 0, 1, 8'h87, 4, 8'h8E, 8, 1, 0);
    do_cmd(8'h0C, 0, 1, 8'h86, 4, 8'h8E, 6, 1, 0);
    for (int m = 4; m <= 8; m++) do_cmd(8'h04, 1, 0, 8'h00, m - 2, 8'h00, m, 1, 0);
    do_cmd(8'h84, 1, 0, 8'h00, 0, 8'h00, 4, 0, 0);
    do_cmd(8'h04, 1, 1, 8'h00, 6, 8'h00, 8, 1, 0);
    do_cmd(8'h04, 1, 0, 8'h00, 2, 8'h00, 9, 1, 1);
    `CHK(exp_done.size() + exp_feed.size() + exp_out.size(), 0)
    report_and_stop();
  end
endmodule
